/* common/tws_pkg.sv */
// Package of register map, field positions, reset values and enums for the two-wire slave.
`default_nettype none
package tws_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [7:0] TWS_OFF_MODE = 8'h00;
  localparam logic [7:0] TWS_OFF_STAT = 8'h04;
  localparam logic [7:0] TWS_OFF_DATA = 8'h08;
  localparam logic [7:0] TWS_OFF_ADDR = 8'h0C;
  localparam logic [7:0] TWS_OFF_CFG = 8'h10;
  // Mode control field positions.
  localparam int TWS_MODE_LSB = 5;
  localparam int TWS_PERIPH_CLOCK_OUT_ENABLE_BIT = 4;
  localparam int TWS_PCKSEL_LSB = 2;
  localparam int TWS_EN_BIT = 1;
  // Status control field positions.
  localparam int TWS_HCF_BIT = 7;
  localparam int TWS_ADDRESS_MATCH_FLAG_BIT = 6;
  localparam int TWS_HBB_BIT = 5;
  localparam int TWS_DIR_BIT = 4;
  localparam int TWS_ACK_TO_SEND_BIT = 3;
  localparam int TWS_SRW_BIT = 2;
  localparam int TWS_WAKE_BIT = 1;
  localparam int TWS_ACK_RECEIVED_FLAG_BIT = 0;
  // Configuration register positions.
  localparam int TWS_DEB_LSB = 0;
  localparam int TWS_PINSEL_BIT = 2;
  // Reset values and the two-wire mode code.
  localparam logic [2:0] TWS_MODE_RST = 3'h7;
  localparam logic [2:0] TWS_MODE_TWS = 3'h6;
  localparam logic [7:0] TWS_STAT_RST = 8'h81;
  localparam logic [2:0] TWS_CFG_RST = 3'h4;
  // Peripheral clock select codes.
  localparam logic [1:0] TWS_PCK_SYS = 2'h0;
  localparam logic [1:0] TWS_PCK_DIV4 = 2'h1;
  localparam logic [1:0] TWS_PCK_DIV8 = 2'h2;
  // Bit count of a byte, acknowledge is the ninth clock.
  localparam logic [3:0] TWS_ACK_IDX = 4'h8;
  typedef enum logic [2:0] {TWS_IDLE, TWS_ADDR, TWS_ADDR_ACK, TWS_DATA, TWS_DATA_ACK, TWS_IGNORE}
    tws_state_e;
endpackage
`default_nettype wire

/* rtl/tws_slave.sv */
// Two-wire slave interface with APB register access and peripheral clock output.
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module tws_slave
  import tws_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic timer0_period_match,
  output logic periph_clock_out_pin,
  output logic wake_req,
  output logic xfer_event
);

  // ------------------------------------------------------------
  // Register bus decode
  // ------------------------------------------------------------
  logic [2:0] mode_r;
  logic pck_en_r;
  logic [1:0] pck_sel_r;
  logic en_r;
  logic hcf_r, address_match_flag_r, hbb_r, dir_r, ack_to_send_r, srw_r, wake_en_r, ack_received_flag_r;
  logic [7:0] data_r;
  logic [7:0] addr_r;
  logic [2:0] cfg_r;
  logic hold_r;
  logic [31:0] rdata_nxt;

  // Decode of accesses; every access completes in its first access cycle.
  wire acc = psel & penable & clk_en;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire hit_mode = (paddr == TWS_OFF_MODE);
  wire hit_stat = (paddr == TWS_OFF_STAT);
  wire hit_data = (paddr == TWS_OFF_DATA);
  wire hit_addr = (paddr == TWS_OFF_ADDR);
  wire hit_cfg = (paddr == TWS_OFF_CFG);
  wire hit_any = hit_mode | hit_stat | hit_data | hit_addr | hit_cfg;
  wire data_rd = rd & hit_data;
  wire [7:0] stat_val = {hcf_r, address_match_flag_r, hbb_r, dir_r, ack_to_send_r, srw_r, wake_en_r, ack_received_flag_r};
  // Enable counts only when the pin routing is selected.
  wire pins_routed = cfg_r[TWS_PINSEL_BIT];
  wire act = en_r & pins_routed & (mode_r == TWS_MODE_TWS);
  wire en_rise = wr & hit_mode & pwdata[TWS_EN_BIT] & ~en_r;

  // Read data multiplexer.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit_mode) begin
      rdata_nxt[7:0] = {mode_r, pck_en_r, pck_sel_r, en_r, 1'b0};
    end else if (hit_stat) begin
      rdata_nxt[7:0] = stat_val;
    end else if (hit_data) begin
      rdata_nxt[7:0] = data_r;
    end else if (hit_addr) begin
      rdata_nxt[7:0] = addr_r;
    end else if (hit_cfg) begin
      rdata_nxt[2:0] = cfg_r;
    end
  end

  // Bus answer registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_any;
      prdata <= (psel & ~penable & ~pwrite) ? rdata_nxt : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // Pin synchronisers and clock debounce
  // ------------------------------------------------------------
  logic [1:0] sda_s, scl_s;
  logic [1:0] scl_hist;
  logic scl_f, sda_d, scl_d;
  wire deb1 = cfg_r[TWS_DEB_LSB];
  wire deb2 = cfg_r[TWS_DEB_LSB + 1];
  wire scl_n = scl_s[1];
  wire all1 = scl_n & scl_hist[0] & (scl_hist[1] | ~deb2);
  wire all0 = ~scl_n & ~scl_hist[0] & (~scl_hist[1] | ~deb2);
  // Filtered clock level follows only a level stable for the debounce time.
  wire scl_nxt = (~deb1 & ~deb2) ? scl_n : (all1 ? 1'b1 : (all0 ? 1'b0 : scl_f));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_s <= 2'h3;
      scl_s <= 2'h3;
      scl_hist <= 2'h3;
      scl_f <= 1'b1;
      sda_d <= 1'b1;
      scl_d <= 1'b1;
    end else if (clk_en) begin
      sda_s <= {sda_s[0], sda_in};
      scl_s <= {scl_s[0], scl_in};
      scl_hist <= {scl_hist[0], scl_n};
      scl_f <= scl_nxt;
      sda_d <= sda_s[1];
      scl_d <= scl_f;
    end
  end

  wire scl_rise = scl_f & ~scl_d;
  wire scl_fall = ~scl_f & scl_d;
  wire start_c = scl_f & scl_d & sda_d & ~sda_s[1];
  wire stop_c = scl_f & scl_d & ~sda_d & sda_s[1];

  // ------------------------------------------------------------
  // Protocol engine
  // ------------------------------------------------------------
  tws_state_e st_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic sda_low_r;
  logic nack_r;
  wire [7:0] sh_in = {sh_r[6:0], sda_s[1]};
  wire addr_ok = (sh_in[7:1] == addr_r[7:1]);
  wire ack_bit = (bit_r == TWS_ACK_IDX);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= TWS_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      sda_low_r <= 1'b0;
      nack_r <= 1'b0;
      hold_r <= 1'b0;
      hcf_r <= 1'b1;
      address_match_flag_r <= 1'b0;
      hbb_r <= 1'b0;
      srw_r <= 1'b0;
      ack_received_flag_r <= 1'b1;
      data_r <= 8'h00;
      xfer_event <= 1'b0;
      wake_req <= 1'b0;
    end else if (clk_en) begin
      xfer_event <= 1'b0;
      wake_req <= 1'b0;
      if (en_rise) begin
        st_r <= TWS_IDLE;
        hcf_r <= 1'b1;
        address_match_flag_r <= 1'b0;
        hbb_r <= 1'b0;
        srw_r <= 1'b0;
        ack_received_flag_r <= 1'b1;
        sda_low_r <= 1'b0;
        hold_r <= 1'b0;
      end else if (!act) begin
        st_r <= TWS_IDLE;
        sda_low_r <= 1'b0;
        hold_r <= 1'b0;
        if (wr && hit_data) begin
          data_r <= pwdata[7:0];
        end
      end else begin
        if (wr && hit_data) begin
          data_r <= pwdata[7:0];
        end
        if (data_rd) begin
          hold_r <= 1'b0;
        end
        if (start_c) begin
          hbb_r <= 1'b1;
          st_r <= TWS_ADDR;
          bit_r <= 4'h0;
          sda_low_r <= 1'b0;
          hold_r <= 1'b0;
        end else if (stop_c) begin
          hbb_r <= 1'b0;
          st_r <= TWS_IDLE;
          sda_low_r <= 1'b0;
          hold_r <= 1'b0;
        end else begin
          unique case (st_r)
            TWS_IDLE, TWS_IGNORE: begin
              sda_low_r <= 1'b0;
            end
            TWS_ADDR: begin
              if (scl_rise) begin
                sh_r <= sh_in;
                bit_r <= bit_r + 4'h1;
                if (bit_r == 4'h7) begin
                  address_match_flag_r <= addr_ok;
                  if (addr_ok) begin
                    srw_r <= sda_s[1];
                    xfer_event <= 1'b1;
                    wake_req <= wake_en_r;
                  end
                end
              end
              if (scl_fall && ack_bit) begin
                st_r <= address_match_flag_r ? TWS_ADDR_ACK : TWS_IGNORE;
                sda_low_r <= address_match_flag_r;
              end
            end
            TWS_ADDR_ACK: begin
              if (scl_fall) begin
                st_r <= TWS_DATA;
                bit_r <= 4'h0;
                hold_r <= ~srw_r;
                sda_low_r <= srw_r & ~data_r[7];
                sh_r <= data_r;
              end
            end
            TWS_DATA: begin
              if (scl_rise) begin
                bit_r <= bit_r + 4'h1;
                // The flag stays set through the acknowledge so software can see it.
                if (bit_r == 4'h0) begin
                  hcf_r <= 1'b0;
                end
                if (!dir_r) begin
                  sh_r <= sh_in;
                end
              end
              if (scl_fall) begin
                if (ack_bit) begin
                  st_r <= TWS_DATA_ACK;
                  hcf_r <= 1'b1;
                  xfer_event <= 1'b1;
                  address_match_flag_r <= 1'b0;
                  if (!dir_r) begin
                    data_r <= sh_r;
                  end
                  sda_low_r <= ~dir_r & ~ack_to_send_r;
                end else if (dir_r) begin
                  sh_r <= {sh_r[6:0], 1'b1};
                  sda_low_r <= ~sh_r[6];
                end
              end
            end
            TWS_DATA_ACK: begin
              if (scl_rise && dir_r) begin
                ack_received_flag_r <= sda_s[1];
                nack_r <= sda_s[1];
              end
              if (scl_fall) begin
                if (dir_r && nack_r) begin
                  st_r <= TWS_IGNORE;
                  sda_low_r <= 1'b0;
                end else begin
                  st_r <= TWS_DATA;
                  bit_r <= 4'h0;
                  sh_r <= data_r;
                  sda_low_r <= dir_r & ~data_r[7];
                end
              end
            end
            default: st_r <= TWS_IDLE;
          endcase
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Software-written registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= TWS_MODE_RST;
      pck_en_r <= 1'b0;
      pck_sel_r <= TWS_PCK_SYS;
      en_r <= 1'b0;
      dir_r <= 1'b0;
      ack_to_send_r <= 1'b0;
      wake_en_r <= 1'b0;
      addr_r <= 8'h00;
      cfg_r <= TWS_CFG_RST;
    end else if (clk_en && wr) begin
      if (hit_mode) begin
        mode_r <= pwdata[TWS_MODE_LSB +: 3];
        pck_en_r <= pwdata[TWS_PERIPH_CLOCK_OUT_ENABLE_BIT];
        pck_sel_r <= pwdata[TWS_PCKSEL_LSB +: 2];
        en_r <= pwdata[TWS_EN_BIT];
      end
      if (hit_stat) begin
        dir_r <= pwdata[TWS_DIR_BIT];
        ack_to_send_r <= pwdata[TWS_ACK_TO_SEND_BIT];
        wake_en_r <= pwdata[TWS_WAKE_BIT];
      end
      if (hit_addr) begin
        addr_r <= pwdata[7:0];
      end
      if (hit_cfg) begin
        cfg_r <= pwdata[2:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Open-drain pin drivers, enable low while pulling low
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b1;
      scl_out <= 1'b0;
      scl_oe <= 1'b1;
    end else if (clk_en) begin
      sda_out <= 1'b0;
      scl_out <= 1'b0;
      sda_oe <= ~(act & sda_low_r);
      scl_oe <= ~(act & hold_r & ~scl_f);
    end
  end

  // ------------------------------------------------------------
  // Peripheral clock output
  // ------------------------------------------------------------
  logic [2:0] pdiv_r;
  logic tm_d, tm_half_r, pck_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdiv_r <= 3'h0;
      tm_d <= 1'b0;
      tm_half_r <= 1'b0;
      pck_r <= 1'b0;
    end else if (clk_en) begin
      pdiv_r <= pdiv_r + 3'h1;
      tm_d <= timer0_period_match;
      if (timer0_period_match && !tm_d) begin
        tm_half_r <= ~tm_half_r;
      end
      pck_r <= ~pck_r;
    end
  end

  // Output select; full rate is a registered toggle giving half of pclk.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_clock_out_pin <= 1'b0;
    end else if (clk_en) begin
      if (!pck_en_r) begin
        periph_clock_out_pin <= 1'b0;
      end else if (pck_sel_r == TWS_PCK_SYS) begin
        periph_clock_out_pin <= ~pck_r;
      end else if (pck_sel_r == TWS_PCK_DIV4) begin
        periph_clock_out_pin <= pdiv_r[1];
      end else if (pck_sel_r == TWS_PCK_DIV8) begin
        periph_clock_out_pin <= pdiv_r[2];
      end else begin
        periph_clock_out_pin <= tm_half_r;
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_busy_start: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && act && start_c && !en_rise |=> hbb_r)
    else $error("busy flag not set after start");
  a_busy_stop: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && act && stop_c && !start_c && !en_rise |=> !hbb_r)
    else $error("busy flag not cleared after stop");
  a_idle_release: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !act |=> sda_oe && scl_oe)
    else $error("pins driven while disabled");
  a_enable_flags: assert property (@(posedge pclk) disable iff (!presetn)
    en_rise |=> hcf_r && !address_match_flag_r && !hbb_r && ack_received_flag_r)
    else $error("flags not restored on enable");
  a_keep_dir: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && act && !(wr && hit_stat) |=> $stable(dir_r) && $stable(ack_to_send_r))
    else $error("direction changed without write");
  a_mode_reset: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(presetn) |-> mode_r == TWS_MODE_RST)
    else $error("mode field reset value wrong");
  a_ack_nomatch: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == TWS_IGNORE |=> sda_oe)
    else $error("data line driven while ignoring");
  a_wake_gate: assert property (@(posedge pclk) disable iff (!presetn)
    wake_req |-> wake_en_r && address_match_flag_r)
    else $error("wake without enable or match");
endmodule
`default_nettype wire

/* sim/tws_bus_master.sv */
// Behavioural two-wire bus master that talks to the slave under test.
`timescale 1ns/1ns
`default_nettype none
module tws_bus_master #(parameter int HALF = 8) (
  input wire logic pclk,
  input wire logic sda_line,
  input wire logic scl_line,
  output logic sda_low,
  output logic scl_low,
  output logic hang
);
  // Both lines start released, so the pull-ups hold the bus idle.
  initial begin
    sda_low = 1'b0;
    scl_low = 1'b0;
    hang = 1'b0;
  end
  // One clock pulse; a clock held low by the slave is waited out, within a bound.
  task automatic bit_cyc(input logic v, output logic s);
    int n;
    n = 0;
    // Data moves only once the slave has seen the clock low, never as a false START.
    repeat (HALF / 2) @(posedge pclk);
    sda_low <= !v;
    repeat (HALF) @(posedge pclk);
    scl_low <= 1'b0;
    @(posedge pclk);
    while (!scl_line && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 4000) hang <= 1'b1;
    repeat (HALF / 2) @(posedge pclk);
    s = sda_line;
    repeat (HALF / 2) @(posedge pclk);
    scl_low <= 1'b1;
  endtask
  // Data falls while the clock is high; only this side makes it.
  task automatic start();
    sda_low <= 1'b1;
    repeat (HALF) @(posedge pclk);
    scl_low <= 1'b1;
    repeat (HALF) @(posedge pclk);
  endtask
  // Data rises while the clock is high, which frees the bus.
  task automatic stop();
    repeat (HALF / 2) @(posedge pclk);
    sda_low <= 1'b1;
    repeat (HALF) @(posedge pclk);
    scl_low <= 1'b0;
    repeat (HALF) @(posedge pclk);
    sda_low <= 1'b0;
    repeat (HALF) @(posedge pclk);
  endtask
  // Sends a byte with its top bit first and returns the acknowledge level.
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(b[i], s);
    bit_cyc(1'b1, ack);
  endtask
  // Reads a byte, then answers with the given acknowledge level.
  task automatic rbyte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(1'b1, b[i]);
    bit_cyc(ack, s);
  endtask
endmodule
`default_nettype wire

/* sim/tb_tws_slave.sv */
// Self-checking testbench of the two-wire slave.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED at %0t got %h expected %h", $time, (a), (e)); end end
module tb_tws_slave import tws_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sda_oe, scl_oe, pck_pin, wake_req, xfer_event, m_sda, m_scl, hang;
  logic tmr = 1'b0, re, ack, ce = 1'b1;
  logic [1:0] tcnt = 2'h0;
  logic [7:0] rq, rb;
  int miscompares = 0, total_checks = 0, ev_cnt = 0, wk_cnt = 0, pck_rises = 0;
  wire sda_line, scl_line;
  // Open-drain lines with pull-ups: low when either side pulls.
  assign sda_line = !(m_sda || !sda_oe);
  assign scl_line = !(m_scl || !scl_oe);
  always #50 pclk = ~pclk;
  // Timer match pulse every four cycles; event pulses counted mid-cycle.
  always @(posedge pclk) begin
    tcnt <= tcnt + 2'h1;
    tmr <= (tcnt == 2'h3);
  end
  always @(negedge pclk) begin
    if (xfer_event === 1'b1) ev_cnt++;
    if (wake_req === 1'b1) wk_cnt++;
  end
  always @(posedge pck_pin) pck_rises++;
  tws_slave DUT (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe),
    .scl_in(scl_line), .scl_out(), .scl_oe(scl_oe), .timer0_period_match(tmr),
    .periph_clock_out_pin(pck_pin), .wake_req(wake_req), .xfer_event(xfer_event));
  tws_bus_master #(.HALF(8)) M (.pclk(pclk), .sda_line(sda_line), .scl_line(scl_line),
    .sda_low(m_sda), .scl_low(m_scl), .hang(hang));
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 16) begin
      miscompares++;
      final_report();
    end
    rq = prdata[7:0];
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset values, every mode code, read-only status bits and a refused address.
  task automatic t_regs();
    rd(TWS_OFF_MODE);
    `CHK(rq, 8'hE0)
    rd(TWS_OFF_STAT);
    `CHK(rq, TWS_STAT_RST)
    rd(8'h14);
    `CHK({re, rq}, 9'h100)
    for (int m = 0; m < 8; m++) begin
      wr(TWS_OFF_MODE, {m[2:0], 5'h02});
      rd(TWS_OFF_MODE);
      `CHK(rq, {m[2:0], 5'h02})
    end
    wr(TWS_OFF_STAT, 8'hFF);
    rd(TWS_OFF_STAT);
    `CHK(rq, 8'h9B)
    wr(TWS_OFF_ADDR, 8'h54);
    rd(TWS_OFF_ADDR);
    `CHK(rq, 8'h54)
  endtask
  // Master writes one byte; clock held until the dummy read.
  task automatic t_write(input logic [7:0] cfg, input logic ack_to_send);
    int e0, w0;
    e0 = ev_cnt;
    w0 = wk_cnt;
    wr(TWS_OFF_CFG, cfg);
    wr(TWS_OFF_MODE, 8'hC2);
    wr(TWS_OFF_STAT, {4'h0, ack_to_send, 3'h2});
    M.start();
    M.wbyte(8'h54, ack);
    `CHK(ack, 1'b0)
    repeat (20) @(posedge pclk);
    `CHK(scl_oe, 1'b0)
    rd(TWS_OFF_STAT);
    `CHK({rq[6:5], rq[2]}, 3'b110)
    rd(TWS_OFF_DATA);
    repeat (4) @(posedge pclk);
    `CHK(scl_oe, 1'b1)
    fork
      M.wbyte(8'hA5, ack);
      begin
        repeat (40) @(posedge pclk);
        rd(TWS_OFF_STAT);
        `CHK(rq[7], 1'b0)
      end
    join
    `CHK(ack, ack_to_send)
    rd(TWS_OFF_DATA);
    `CHK(rq, 8'hA5)
    rd(TWS_OFF_STAT);
    `CHK(rq[7], 1'b1)
    M.stop();
    rd(TWS_OFF_STAT);
    `CHK(rq[5], 1'b0)
    `CHK(ev_cnt - e0, 2)
    `CHK(wk_cnt - w0, 1)
  endtask
  // Master reads one byte and acknowledges it or not.
  task automatic t_read(input logic [7:0] d, input logic mack);
    wr(TWS_OFF_STAT, 8'h10);
    wr(TWS_OFF_DATA, d);
    M.start();
    M.wbyte(8'h55, ack);
    `CHK(ack, 1'b0)
    rd(TWS_OFF_STAT);
    `CHK(rq[2], 1'b1)
    M.rbyte(mack, rb);
    `CHK(rb, d)
    rd(TWS_OFF_STAT);
    `CHK(rq[0], mack)
    if (mack) `CHK(sda_oe, 1'b1)
    M.stop();
  endtask
  // No routing, unused mode, disabled, then a foreign address: never acknowledged.
  task automatic t_refuse();
    logic [7:0] cfgs [3] = '{8'h00, 8'h04, 8'h04};
    logic [7:0] modes [3] = '{8'hC2, 8'hE2, 8'hC0};
    for (int k = 0; k < 3; k++) begin
      wr(TWS_OFF_CFG, cfgs[k]);
      wr(TWS_OFF_MODE, modes[k]);
      M.start();
      M.wbyte(8'h54, ack);
      `CHK({ack, sda_oe, scl_oe}, 3'b111)
      M.stop();
    end
    wr(TWS_OFF_MODE, 8'hC2);
    M.start();
    M.wbyte(8'h56, ack);
    rd(TWS_OFF_STAT);
    `CHK({ack, rq[6]}, 2'b10)
    M.stop();
  endtask
  // Re-enable in mid-transfer: flags return to reset, direction and ack bits stay.
  task automatic t_enable();
    wr(TWS_OFF_STAT, 8'h18);
    M.start();
    M.wbyte(8'h55, ack);
    wr(TWS_OFF_MODE, 8'hC0);
    repeat (2) @(posedge pclk);
    `CHK({sda_oe, scl_oe}, 2'b11)
    wr(TWS_OFF_MODE, 8'hC2);
    rd(TWS_OFF_STAT);
    `CHK(rq, 8'h99)
    M.stop();
  endtask
  // Clock output for each select code, then disabled.
  task automatic t_pck();
    int exp [5] = '{1, 20, 10, 10, 0};
    for (int k = 0; k < 5; k++) begin
      wr(TWS_OFF_MODE, {3'h6, k < 4, k[1:0], 2'h2});
      repeat (8) @(posedge pclk);
      pck_rises = 0;
      repeat (80) @(posedge pclk);
      `CHK(k == 0 ? pck_rises > 0 : pck_rises >= exp[k] - 1 && pck_rises <= exp[k] + 1, 1'b1)
      // With the clock enable low the divided output must freeze.
      if (k == 1) begin
        ce <= 1'b0;
        repeat (2) @(posedge pclk);
        rb[0] = pck_pin;
        repeat (6) @(posedge pclk);
        `CHK(pck_pin, rb[0])
        ce <= 1'b1;
      end
    end
  endtask
  // Main sequence after four cycles of reset.
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_write(8'h04, 1'b0);
    t_write(8'h05, 1'b1);
    t_write(8'h06, 1'b0);
    t_read(8'hBC, 1'b0);
    t_read(8'h3C, 1'b1);
    t_refuse();
    t_enable();
    t_pck();
    final_report();
  end
  // A stuck bus or a run past its bound ends as a mismatch.
  always @(posedge hang) begin
    miscompares++;
    final_report();
  end
  initial begin
    repeat (100000) @(posedge pclk);
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire
